// ===== hdl/rsc_pkg.sv
// Purpose: Shared constants for the resonance suppression stage
// Assumes: 16-bit parameter words, 40 MHz control clock
// Notes: Parameter addresses are word addresses on the parameter port
package rsc_pkg;
   // Parameter addresses
   localparam logic [15:0] ADDR_NOTCH1_FREQ = 16'h022E;
   localparam logic [15:0] ADDR_NOTCH1_ATTEN = 16'h0230;
   localparam logic [15:0] ADDR_LOWPASS_TIME = 16'h0232;
   localparam logic [15:0] ADDR_NOTCH2_FREQ = 16'h0256;
   localparam logic [15:0] ADDR_NOTCH2_ATTEN = 16'h0258;
   localparam logic [15:0] ADDR_NOTCH3_FREQ = 16'h025A;
   localparam logic [15:0] ADDR_NOTCH3_ATTEN = 16'h025C;
   localparam logic [15:0] ADDR_AUTO_MODE = 16'h025E;
   // Value ranges
   localparam logic [15:0] ATTEN_MAX = 16'h0020;
   localparam logic [15:0] LP_TIME_MAX = 16'h03E8;
   localparam logic [15:0] MAN_FREQ_MIN = 16'h0032;
   localparam logic [15:0] MAN_FREQ_MAX = 16'h03E8;
   localparam logic [15:0] AUTO_FREQ_MIN = 16'h0032;
   localparam logic [15:0] AUTO_FREQ_MAX = 16'h07D0;
   // Reset values
   localparam logic [15:0] AUTO_FREQ_RST = 16'h03E8;
   localparam logic [15:0] ATTEN_RST = 16'h0000;
   localparam logic [15:0] MAN_FREQ_RST = 16'h03E8;
   localparam logic [15:0] LP_TIME_RST = 16'h0002;
   // Auto mode codes
   typedef enum logic [1:0] {
      RSC_AUTO_OFF = 2'b00,
      RSC_AUTO_ONCE = 2'b01,
      RSC_AUTO_CONT = 2'b10
   } rsc_mode_e;
   // Timing
   localparam longint unsigned CLK_HZ = 40_000_000;
   localparam longint unsigned STABLE_TIME_MIN = 20;
   localparam longint unsigned STABLE_CYCLES = STABLE_TIME_MIN * 60 * CLK_HZ;
   localparam longint unsigned LP_STEP_US = 100;
   localparam int LP_STEP_CYCLES = int'(LP_STEP_US * CLK_HZ / 1_000_000);
endpackage

// ===== hdl/rsc_lowpass.sv
// Purpose: First-order low-pass on the torque command, step 0.1 ms
// Assumes: Time constant already limited to 0..1000 counts
// Notes: Gain is a power-of-two approximation of step / time constant
`timescale 1ns/10ps
module rsc_lowpass
   import rsc_pkg::*;
#(
   parameter int W = 16,
   parameter int TICK = LP_STEP_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [15:0] timeConst,
   input wire logic signed [W-1:0] dataIn,
   output logic signed [W-1:0] dataOut
);
   // Elaboration check: the step timer is 13 bits wide
   if (W < 2 || TICK < 1 || TICK > 8192) begin : gBadParams
      $error("rsc_lowpass: bad parameters");
   end
   logic [12:0] tick_q;
   logic signed [W-1:0] y_q;
   logic [3:0] shiftAmt;
   wire tickHit = (tick_q == 13'(TICK - 1));
   wire bypass = (timeConst == 16'h0000);
   wire signed [W:0] diff = {dataIn[W-1], dataIn} - {y_q[W-1], y_q};
   wire signed [W:0] step = diff >>> shiftAmt;
   // Shift amount is the bit length of the time constant
   always_comb begin
      shiftAmt = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (timeConst[i]) shiftAmt = 4'(i + 1);
      end
   end
   // Filter step timer
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) tick_q <= 13'h0000;
      else tick_q <= tickHit ? 13'h0000 : tick_q + 13'h0001;
   end
   // Zero time constant passes the input straight to the register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) y_q <= '0;
      else if (bypass) y_q <= dataIn; // RULE_02
      else if (tickHit) y_q <= W'(y_q + W'(step));
   end
   assign dataOut = y_q;

   lp_bypass_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_02
      bypass |=> dataOut == $past(dataIn)) else $error("low-pass not bypassed");
endmodule // rsc_lowpass

// ===== hdl/rsc_resonance_ctrl.sv
// Purpose: Auto and manual resonance suppression parameter control
// Assumes: Resonance search engine and filters share the control clock
// Notes: Parameter port is the panel or software communication path
`timescale 1ns/10ps
// Contract
// [RULE_01] Third notch depth 0..32 dB; zero bypasses that notch.
// [RULE_02] Low-pass time in 0.1 ms steps, 0..1000; zero bypasses it.
// [RULE_03] Auto filters form two frequency/attenuation sets, notch two and three.
// [RULE_04] Active tuning stores found frequency and depth into both sets.
// [RULE_05] One-shot mode returns to off after completion and 20 stable minutes.
// [RULE_06] Continuous mode keeps searching and never clears itself.
// [RULE_07] Writing 1 anytime, or 2 from off, clears the four and starts tuning.
// [RULE_08] Writing 0 while active keeps the four and stops tuning.
// [RULE_09] Writing 2 while active keeps the four and continues tuning.
// [RULE_10] Manual notch frequency 50..1000 Hz, depth 0..32 dB.
// [RULE_11] Auto frequencies default to 1000 until tuning writes them.
module rsc_resonance_ctrl
   import rsc_pkg::*;
#(
   parameter longint unsigned STABLE_LIMIT = STABLE_CYCLES,
   parameter int CNT_W = 36,
   parameter int TORQUE_W = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic paramWr,
   input wire logic paramRd,
   input wire logic [15:0] paramAddr,
   input wire logic [15:0] paramWrData,
   output logic [15:0] paramRdData,
   output logic paramRdValid,
   input wire logic tuneFound,
   input wire logic [15:0] tuneFreq,
   input wire logic [15:0] tuneAtten,
   input wire logic systemStable,
   output logic tuneEnable,
   output logic tuneRestart,
   output logic [15:0] notch1Freq,
   output logic [15:0] notch1Atten,
   output logic [15:0] notch2Freq,
   output logic [15:0] notch2Atten,
   output logic [15:0] notch3Freq,
   output logic [15:0] notch3Atten,
   output logic notch1Active,
   output logic notch2Active,
   output logic notch3Active,
   output logic lowpassActive,
   output logic [1:0] autoMode,
   input wire logic signed [TORQUE_W-1:0] torqueIn,
   output logic signed [TORQUE_W-1:0] torqueOut
);
   // Elaboration check: the stability timer must be able to reach its limit
   if (CNT_W < 2 || CNT_W > 63 || STABLE_LIMIT < 1 ||
       STABLE_LIMIT >= (64'd1 << CNT_W)) begin : gBadCount
      $error("rsc_resonance_ctrl: counter too narrow");
   end

   function automatic logic [15:0] clampVal(logic [15:0] v, logic [15:0] lo, logic [15:0] hi);
      clampVal = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   logic [15:0] notch1Freq_q, notch1Atten_q, lowpassTime_q;
   logic [15:0] notch2Freq_q, notch2Atten_q, notch3Freq_q, notch3Atten_q;
   rsc_mode_e mode_q, mode_d;
   logic done_q;
   logic [CNT_W-1:0] stableCnt_q;
   logic [15:0] paramRdData_q;
   logic paramRdValid_q;

   // Address decode
   wire wrN1F = paramWr && paramAddr == ADDR_NOTCH1_FREQ;
   wire wrN1A = paramWr && paramAddr == ADDR_NOTCH1_ATTEN;
   wire wrLp = paramWr && paramAddr == ADDR_LOWPASS_TIME;
   wire wrN2F = paramWr && paramAddr == ADDR_NOTCH2_FREQ;
   wire wrN2A = paramWr && paramAddr == ADDR_NOTCH2_ATTEN;
   wire wrN3F = paramWr && paramAddr == ADDR_NOTCH3_FREQ;
   wire wrN3A = paramWr && paramAddr == ADDR_NOTCH3_ATTEN;
   wire wrMode = paramWr && paramAddr == ADDR_AUTO_MODE && paramWrData <= 16'h0002;
   wire [1:0] wrModeVal = paramWrData[1:0];

   // Mode write decisions
   wire modeActive = (mode_q != RSC_AUTO_OFF);
   wire startClear = wrMode && (wrModeVal == RSC_AUTO_ONCE || // RULE_07
                     (wrModeVal == RSC_AUTO_CONT && !modeActive)); // RULE_07
   wire tuneStore = tuneFound && modeActive; // RULE_04
   wire stableHit = (mode_q == RSC_AUTO_ONCE) && done_q && systemStable &&
                    (stableCnt_q == CNT_W'(STABLE_LIMIT - 1));

   // Clamped write data and tuning results
   wire [15:0] manFreqIn = clampVal(paramWrData, MAN_FREQ_MIN, MAN_FREQ_MAX); // RULE_10
   wire [15:0] attenIn = clampVal(paramWrData, 16'h0000, ATTEN_MAX); // RULE_01
   wire [15:0] autoFreqIn = clampVal(paramWrData, AUTO_FREQ_MIN, AUTO_FREQ_MAX);
   wire [15:0] lpIn = clampVal(paramWrData, 16'h0000, LP_TIME_MAX); // RULE_02
   wire [15:0] tFreq = clampVal(tuneFreq, AUTO_FREQ_MIN, AUTO_FREQ_MAX);
   wire [15:0] tAtten = clampVal(tuneAtten, 16'h0000, ATTEN_MAX);

   // Next mode: software write beats self clear
   always_comb begin
      mode_d = mode_q;
      if (wrMode) begin
         case (wrModeVal)
            2'b00: mode_d = RSC_AUTO_OFF; // RULE_08
            2'b01: mode_d = RSC_AUTO_ONCE;
            2'b10: mode_d = RSC_AUTO_CONT; // RULE_09
            default: mode_d = mode_q;
         endcase
      end else if (stableHit) begin
         mode_d = RSC_AUTO_OFF; // RULE_05
      end
   end

   // Manual notch and low-pass parameters
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         notch1Freq_q <= MAN_FREQ_RST;
         notch1Atten_q <= ATTEN_RST;
         lowpassTime_q <= LP_TIME_RST;
      end else begin
         if (wrN1F) notch1Freq_q <= manFreqIn; // RULE_10
         if (wrN1A) notch1Atten_q <= attenIn; // RULE_10
         if (wrLp) lowpassTime_q <= lpIn; // RULE_02
      end
   end

   // Auto sets: tuning beats clear and software writes in the same cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         notch2Freq_q <= AUTO_FREQ_RST; // RULE_11
         notch3Freq_q <= AUTO_FREQ_RST; // RULE_11
         notch2Atten_q <= ATTEN_RST;
         notch3Atten_q <= ATTEN_RST;
      end else if (tuneStore) begin
         notch2Freq_q <= tFreq; // RULE_04
         notch3Freq_q <= tFreq; // RULE_03
         notch2Atten_q <= tAtten; // RULE_04
         notch3Atten_q <= tAtten; // RULE_03
      end else if (startClear) begin
         notch2Freq_q <= AUTO_FREQ_RST; // RULE_07
         notch3Freq_q <= AUTO_FREQ_RST; // RULE_11
         notch2Atten_q <= ATTEN_RST;
         notch3Atten_q <= ATTEN_RST;
      end else begin
         if (wrN2F) notch2Freq_q <= autoFreqIn;
         if (wrN2A) notch2Atten_q <= attenIn;
         if (wrN3F) notch3Freq_q <= autoFreqIn;
         if (wrN3A) notch3Atten_q <= attenIn; // RULE_01
      end
   end

   // Mode, completion flag and stability timer
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_q <= RSC_AUTO_OFF;
         done_q <= 1'b0;
         stableCnt_q <= '0;
      end else begin
         mode_q <= mode_d;
         // A result in the restart cycle wins, like the stored notch values
         done_q <= (tuneStore || (done_q && !startClear)) && mode_d != RSC_AUTO_OFF;
         if (startClear || !systemStable || !done_q || stableHit || wrMode)
            stableCnt_q <= '0; // RULE_05
         else
            stableCnt_q <= stableCnt_q + 1'b1;
      end
   end

   // Registered read port
   wire [15:0] rdMux =
      (paramAddr == ADDR_NOTCH1_FREQ) ? notch1Freq_q :
      (paramAddr == ADDR_NOTCH1_ATTEN) ? notch1Atten_q :
      (paramAddr == ADDR_LOWPASS_TIME) ? lowpassTime_q :
      (paramAddr == ADDR_NOTCH2_FREQ) ? notch2Freq_q :
      (paramAddr == ADDR_NOTCH2_ATTEN) ? notch2Atten_q :
      (paramAddr == ADDR_NOTCH3_FREQ) ? notch3Freq_q :
      (paramAddr == ADDR_NOTCH3_ATTEN) ? notch3Atten_q :
      (paramAddr == ADDR_AUTO_MODE) ? {14'h0000, mode_q} : 16'h0000;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         paramRdData_q <= 16'h0000;
         paramRdValid_q <= 1'b0;
      end else begin
         paramRdValid_q <= paramRd;
         if (paramRd) paramRdData_q <= rdMux;
      end
   end

   // Outputs
   assign paramRdData = paramRdData_q;
   assign paramRdValid = paramRdValid_q;
   assign tuneEnable = modeActive; // RULE_06
   assign tuneRestart = startClear;
   assign autoMode = mode_q;
   assign notch1Freq = notch1Freq_q;
   assign notch1Atten = notch1Atten_q;
   assign notch2Freq = notch2Freq_q;
   assign notch2Atten = notch2Atten_q;
   assign notch3Freq = notch3Freq_q;
   assign notch3Atten = notch3Atten_q;
   assign notch1Active = (notch1Atten_q != 16'h0000);
   assign notch2Active = (notch2Atten_q != 16'h0000);
   assign notch3Active = (notch3Atten_q != 16'h0000); // RULE_01
   assign lowpassActive = (lowpassTime_q != 16'h0000); // RULE_02

   // Torque low-pass stage
   rsc_lowpass #(.W(TORQUE_W), .TICK(LP_STEP_CYCLES)) uLowpass (
      .clk(clk),
      .sys_rst(sys_rst),
      .timeConst(lowpassTime_q),
      .dataIn(torqueIn),
      .dataOut(torqueOut)
   );

   // Checks
   notch3_bypass_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
      wrN3A && paramWrData == 16'h0000 && !tuneStore && !startClear |=> !notch3Active)
      else $error("notch three not bypassed");
   lowpass_range_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_02
      wrLp |=> lowpassTime_q == (($past(paramWrData) > LP_TIME_MAX) ? LP_TIME_MAX
      : $past(paramWrData))) else $error("low-pass time wrong");
   set_pairing_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_03
      tuneStore |=> notch2Freq == notch3Freq && notch2Atten == notch3Atten)
      else $error("auto sets differ");
   tune_store_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
      tuneStore && tuneAtten <= ATTEN_MAX |=> notch2Atten == $past(tuneAtten))
      else $error("tuned depth not stored");
   oneshot_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
      stableHit && !wrMode |=> autoMode == RSC_AUTO_OFF && !tuneEnable)
      else $error("one-shot mode not cleared");
   cont_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_06
      mode_q == RSC_AUTO_CONT && !wrMode |=> autoMode == RSC_AUTO_CONT)
      else $error("continuous mode dropped");
   start_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_07
      wrMode && wrModeVal == 2'b01 && !tuneFound |=> notch2Freq == AUTO_FREQ_RST &&
      notch3Atten == 16'h0000 && autoMode == RSC_AUTO_ONCE) else $error("start not cleared");
   stop_keep_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_08
      wrMode && wrModeVal == 2'b00 && modeActive && !tuneFound |=> $stable(notch2Freq) &&
      $stable(notch3Atten) && !tuneEnable) else $error("stop altered settings");
   cont_keep_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_09
      wrMode && wrModeVal == 2'b10 && modeActive && !tuneFound |=> $stable(notch2Atten) &&
      $stable(notch3Freq) && !tuneRestart) else $error("continue restarted");
   man_range_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_10
      notch1Freq >= MAN_FREQ_MIN && notch1Freq <= MAN_FREQ_MAX && notch1Atten <= ATTEN_MAX)
      else $error("manual notch out of range");
   freq_default_a: assert property (@(posedge clk) // RULE_11
      $fell(sys_rst) |-> notch2Freq == AUTO_FREQ_RST && notch3Freq == AUTO_FREQ_RST)
      else $error("auto frequency default wrong");

   tune_c: cover property (@(posedge clk) disable iff (sys_rst) tuneStore);
   oneshot_c: cover property (@(posedge clk) disable iff (sys_rst) stableHit);
   cont_c: cover property (@(posedge clk) disable iff (sys_rst)
      wrMode && wrModeVal == 2'b10 && mode_q == RSC_AUTO_ONCE);
endmodule // rsc_resonance_ctrl

// ===== dv/tb_top.sv
// Purpose: Self-checking bench for the resonance suppression control block
// Assumes: Stability limit shortened to 20 cycles; parameter port driven directly
// Notes: Tasks speak the strobe protocol of the parameter port
`timescale 1ns/10ps
`define CHECK_EQ(what, exp, got) \
   begin \
      totalChecks++; \
      if ((got) !== (exp)) begin \
         badCount++; \
         $display("wrong value %s expected %h seen %h", what, exp, got); \
      end \
   end
module tb_top
   import rsc_pkg::*;
;
   logic clk, sys_rst, paramWr, paramRd, tuneFound, systemStable, lastRestart;
   logic [15:0] paramAddr, paramWrData, tuneFreq, tuneAtten;
   logic [15:0] paramRdData, notch1Freq, notch1Atten, notch2Freq, notch2Atten;
   logic [15:0] notch3Freq, notch3Atten;
   logic paramRdValid, tuneEnable, tuneRestart, notch1Active, notch2Active;
   logic notch3Active, lowpassActive;
   logic [1:0] autoMode;
   logic signed [15:0] torqueIn, torqueOut;
   int badCount = 0;
   int totalChecks = 0;

   rsc_resonance_ctrl #(.STABLE_LIMIT(20)) dut (
      .clk(clk), .sys_rst(sys_rst), .paramWr(paramWr), .paramRd(paramRd),
      .paramAddr(paramAddr), .paramWrData(paramWrData), .paramRdData(paramRdData),
      .paramRdValid(paramRdValid), .tuneFound(tuneFound), .tuneFreq(tuneFreq),
      .tuneAtten(tuneAtten), .systemStable(systemStable), .tuneEnable(tuneEnable),
      .tuneRestart(tuneRestart), .notch1Freq(notch1Freq), .notch1Atten(notch1Atten),
      .notch2Freq(notch2Freq), .notch2Atten(notch2Atten), .notch3Freq(notch3Freq),
      .notch3Atten(notch3Atten), .notch1Active(notch1Active),
      .notch2Active(notch2Active), .notch3Active(notch3Active),
      .lowpassActive(lowpassActive), .autoMode(autoMode), .torqueIn(torqueIn),
      .torqueOut(torqueOut));

   // Clock at 40 MHz
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Prints the counts and the verdict, then stops
   task automatic conclude();
      $display("checks %0d mismatches %0d", totalChecks, badCount);
      if (badCount == 0 && totalChecks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // One parameter write; the restart pulse is sampled while the strobe is up
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      paramWr <= 1'b1;
      paramAddr <= a;
      paramWrData <= d;
      #1;
      lastRestart = tuneRestart;
      @(posedge clk);
      paramWr <= 1'b0;
      #1;
   endtask

   // One parameter read, compared in the cycle the valid pulse stands
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk);
      paramRd <= 1'b1;
      paramAddr <= a;
      @(posedge clk);
      paramRd <= 1'b0;
      #1;
      `CHECK_EQ("read valid", 1'b1, paramRdValid)
      `CHECK_EQ("read data", exp, paramRdData)
   endtask

   // One search result pulse from the resonance engine
   task automatic tune(input logic [15:0] f, input logic [15:0] a);
      @(posedge clk);
      tuneFound <= 1'b1;
      tuneFreq <= f;
      tuneAtten <= a;
      @(posedge clk);
      tuneFound <= 1'b0;
      #1;
   endtask

   // Compares both auto notch sets against one pair
   task automatic autos(input logic [15:0] f, input logic [15:0] a);
      `CHECK_EQ("notch2 freq", f, notch2Freq)
      `CHECK_EQ("notch3 freq", f, notch3Freq)
      `CHECK_EQ("notch2 atten", a, notch2Atten)
      `CHECK_EQ("notch3 atten", a, notch3Atten)
   endtask

   // Mode write with expected mode and restart pulse
   task automatic mode(input logic [15:0] d, input logic [1:0] m, input logic rs);
      wr(ADDR_AUTO_MODE, d);
      `CHECK_EQ("auto mode", m, autoMode)
      `CHECK_EQ("restart pulse", rs, lastRestart)
      `CHECK_EQ("tune enable", (m != 2'b00), tuneEnable)
   endtask

   // Holds stability for a number of cycles
   task automatic stable(input int n);
      @(posedge clk);
      systemStable <= 1'b1;
      repeat (n - 1) @(posedge clk);
      #1;
   endtask

   // Watchdog against a hang
   initial begin
      repeat (5000) @(posedge clk);
      badCount++;
      conclude();
   end

   // Main sequence
   initial begin
      sys_rst = 1'b1;
      {paramWr, paramRd, tuneFound, systemStable, lastRestart} = '0;
      {paramAddr, paramWrData, tuneFreq, tuneAtten} = '0;
      torqueIn = 16'sh0000;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      autos(AUTO_FREQ_RST, ATTEN_RST);
      rd(ADDR_NOTCH3_ATTEN, 16'h0000);
      rd(ADDR_LOWPASS_TIME, LP_TIME_RST);
      rd(16'h0100, 16'h0000);
      `CHECK_EQ("lp active", 1'b1, lowpassActive)
      $display("test reset done");
      wr(ADDR_NOTCH3_ATTEN, 16'h0028);
      `CHECK_EQ("n3 atten", ATTEN_MAX, notch3Atten)
      `CHECK_EQ("n3 active", 1'b1, notch3Active)
      wr(ADDR_NOTCH3_ATTEN, 16'h0000);
      `CHECK_EQ("n3 bypass", 1'b0, notch3Active)
      wr(ADDR_LOWPASS_TIME, 16'h05DC);
      rd(ADDR_LOWPASS_TIME, LP_TIME_MAX);
      wr(ADDR_LOWPASS_TIME, 16'h0000);
      `CHECK_EQ("lp bypass", 1'b0, lowpassActive)
      @(posedge clk);
      torqueIn <= 16'sh1234;
      repeat (2) @(posedge clk);
      #1;
      `CHECK_EQ("torque out", 16'sh1234, torqueOut)
      wr(ADDR_NOTCH1_FREQ, 16'h000A);
      `CHECK_EQ("n1 freq low", MAN_FREQ_MIN, notch1Freq)
      wr(ADDR_NOTCH1_FREQ, 16'h07D0);
      `CHECK_EQ("n1 freq high", MAN_FREQ_MAX, notch1Freq)
      wr(ADDR_NOTCH1_ATTEN, 16'h0021);
      `CHECK_EQ("n1 atten", ATTEN_MAX, notch1Atten)
      `CHECK_EQ("n1 active", 1'b1, notch1Active)
      rd(ADDR_NOTCH1_FREQ, MAN_FREQ_MAX);
      rd(ADDR_NOTCH1_ATTEN, ATTEN_MAX);
      wr(ADDR_NOTCH2_FREQ, 16'h0010);
      rd(ADDR_NOTCH2_FREQ, AUTO_FREQ_MIN);
      wr(ADDR_NOTCH3_FREQ, 16'h0FA0);
      rd(ADDR_NOTCH3_FREQ, AUTO_FREQ_MAX);
      wr(ADDR_NOTCH2_ATTEN, 16'h0005);
      rd(ADDR_NOTCH2_ATTEN, 16'h0005);
      $display("test ranges done");
      mode(16'h0001, RSC_AUTO_ONCE, 1'b1);
      autos(AUTO_FREQ_RST, ATTEN_RST);
      tune(16'h0FA0, 16'h0030);
      autos(AUTO_FREQ_MAX, ATTEN_MAX);
      tune(16'h012C, 16'h000C);
      autos(16'h012C, 16'h000C);
      `CHECK_EQ("n2 active", 1'b1, notch2Active & notch3Active)
      mode(16'h0002, RSC_AUTO_CONT, 1'b0);
      mode(16'h0002, RSC_AUTO_CONT, 1'b0);
      mode(16'h0003, RSC_AUTO_CONT, 1'b0);
      autos(16'h012C, 16'h000C);
      mode(16'h0000, RSC_AUTO_OFF, 1'b0);
      tune(16'h0200, 16'h0005);
      autos(16'h012C, 16'h000C);
      mode(16'h0002, RSC_AUTO_CONT, 1'b1);
      autos(AUTO_FREQ_RST, ATTEN_RST);
      tune(16'h0200, 16'h0005);
      mode(16'h0001, RSC_AUTO_ONCE, 1'b1);
      autos(AUTO_FREQ_RST, ATTEN_RST);
      tune(16'h0200, 16'h0005);
      mode(16'h0001, RSC_AUTO_ONCE, 1'b1);
      autos(AUTO_FREQ_RST, ATTEN_RST);
      $display("test modes done");
      tune(16'h0190, 16'h0008);
      stable(15);
      systemStable <= 1'b0;
      stable(16);
      `CHECK_EQ("once held", RSC_AUTO_ONCE, autoMode)
      repeat (10) @(posedge clk);
      #1;
      `CHECK_EQ("once cleared", RSC_AUTO_OFF, autoMode)
      autos(16'h0190, 16'h0008);
      rd(ADDR_AUTO_MODE, 16'h0000);
      systemStable <= 1'b0;
      mode(16'h0002, RSC_AUTO_CONT, 1'b1);
      tune(16'h0150, 16'h0006);
      stable(40);
      `CHECK_EQ("cont kept", RSC_AUTO_CONT, autoMode)
      tune(16'h0160, 16'h0007);
      autos(16'h0160, 16'h0007);
      rd(ADDR_AUTO_MODE, 16'h0002);
      systemStable <= 1'b0;
      $display("test stability done");
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      autos(AUTO_FREQ_RST, ATTEN_RST);
      rd(ADDR_LOWPASS_TIME, LP_TIME_RST);
      $display("test second reset done");
      conclude();
   end
endmodule // tb_top
